// *** design/hbfm_monitor.sv ***
`timescale 1ns/1ps
// Behaviour
// - detected load-supply undervoltage sets supply-fail flag and disables all switches.
// - undervoltage counts only after persisting longer than the undervoltage filter time.
// - switches come back immediately once the supply recovers.
// - supply-fail flag stays high until a status clear.
// - on-state switch below open-load current past shutdown filter time sets open-load flag.
// - open-load flag stays high until a status clear.
// - prewarning flag follows the hysteretic prewarning temperature comparator.
// - prewarning flag appears on serial out at chip-select fall.
// - transfer aborted early leaves input and output words unchanged.
// - thermal shutdown disables all switches, their status bits read low.
// - after thermal shutdown, re-enable needs cool temperature and a status clear.
// - overcurrent shutdown acts only while trip enable bit is high.
// - tripped overcurrent past filter time turns switch off and sets short flag.
// - with trip disabled overcurrent sets short flag, switches untouched.
// - status clear resets short flag and re-enables tripped switches.
// - sleep low turns switches off to high impedance and erases words.
// - sleep back high restarts the block from its power-on state.
// - status word: prewarn bit 0, short 13, open-load 14, supply-fail 15.
// - after reset input word has trip enable high, clear and switch bits low.
// - status bits 1 to 6 show actual switch state, untouched by clear.
module hbfm_monitor
  import hbfm_pkg::*;
#(
  parameter int CNT_W  = 12,
  parameter int UV_CYC = UV_FILTER_CYC,
  parameter int SD_CYC = SD_FILTER_CYC
) (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic              sleep_input_n_i,
  input  wire logic              cs_n_i,
  input  wire logic              sclk_i,
  input  wire logic              sdi_i,
  input  wire logic              load_supply_low_i,
  input  wire logic [NUM_SW-1:0] open_load_raw_i,
  input  wire logic [NUM_SW-1:0] overcurrent_raw_i,
  input  wire logic              prewarn_on_temp_i,
  input  wire logic              shutdown_temp_i,
  input  wire logic              below_on_temp_i,
  output logic                   sdo_o,
  output logic                   sdo_oe_o,
  output logic [NUM_SW-1:0]      switch_en_o,
  output logic                   outputs_hiz_o,
  output logic                   supply_fail_flag_o,
  output logic                   open_load_flag_o,
  output logic                   short_trip_flag_o,
  output logic                   prewarn_flag_o
);

  if (UV_CYC < 1 || SD_CYC < 1 || UV_CYC >= 2**CNT_W || SD_CYC >= 2**CNT_W) begin : g_bad_cnt
    $error("filter counts do not fit the counter width");
  end

  localparam int SYNC_W = 5 + 2 * NUM_SW + 3;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic              awake_s;
  logic              cs_n_s;
  logic              sclk_s;
  logic              sdi_s;
  logic              uv_s;
  logic [NUM_SW-1:0] ol_s;
  logic [NUM_SW-1:0] oc_s;
  logic              pw_s;
  logic              shut_s;
  logic              cool_s;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {sleep_input_n_i, cs_n_i, sclk_i, sdi_i, load_supply_low_i,
                  open_load_raw_i, overcurrent_raw_i, prewarn_on_temp_i,
                  shutdown_temp_i, below_on_temp_i};
      sync2_q <= sync1_q;
    end
  end

  assign {awake_s, cs_n_s, sclk_s, sdi_s, uv_s, ol_s, oc_s, pw_s, shut_s, cool_s} = sync2_q;

  // sleep holds the whole block in its power-on state; release is the restart
  logic asleep;
  assign asleep = ~awake_s;

  function automatic logic [CNT_W-1:0] filt_step(input logic             cond,
                                                 input logic [CNT_W-1:0] cnt,
                                                 input logic [CNT_W-1:0] term);
    if (!cond) begin
      filt_step = '0;
    end else if (cnt == term) begin
      filt_step = cnt;
    end else begin
      filt_step = cnt + 1'b1;
    end
  endfunction

  localparam logic [CNT_W-1:0] UV_TERM = CNT_W'(UV_CYC);
  localparam logic [CNT_W-1:0] SD_TERM = CNT_W'(SD_CYC);

  // ****************************************************************
  // serial link
  // ****************************************************************
  hbfm_link_t        state_q;
  logic              sclk_prev_q;
  logic [4:0]        bit_cnt_q;
  logic [WORD_W-1:0] rx_q;
  logic [WORD_W-1:0] tx_q;
  logic [WORD_W-1:0] ctrl_q;
  logic              clear_pulse_q;
  logic              sdo_q;
  logic              sdo_oe_q;
  logic [WORD_W-1:0] status_word;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              accept;
  logic              uv_det_q;
  logic              supply_fail_q;
  logic              open_load_q;
  logic              short_q;
  logic              prewarn_q;
  logic              therm_off_q;
  logic [NUM_SW-1:0] trip_q;
  logic [NUM_SW-1:0] switch_en_q;
  logic              hiz_q;

  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  // a word counts only when exactly sixteen clocks came in; anything else is an abort
  assign accept    = (state_q == HBFM_SHIFT) && cs_n_s && (bit_cnt_q == WORD_BITS);

  assign status_word = {supply_fail_q, open_load_q, short_q, 6'h00, switch_en_q, prewarn_q};

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_prev_q <= 1'b0;
      state_q   <= HBFM_IDLE;
      bit_cnt_q <= '0;
      rx_q      <= '0;
      tx_q      <= '0;
      sdo_q     <= 1'b0;
      sdo_oe_q  <= 1'b0;
    end else if (asleep) begin
      sclk_prev_q <= sclk_s;
      state_q   <= HBFM_IDLE;
      bit_cnt_q <= '0;
      rx_q      <= '0;
      tx_q      <= '0;
      sdo_q     <= 1'b0;
      sdo_oe_q  <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      unique case (state_q)
        HBFM_IDLE: begin
          if (!cs_n_s) begin
            state_q   <= HBFM_SHIFT;
            bit_cnt_q <= '0;
            tx_q      <= status_word;
            sdo_q     <= status_word[PREWARN_BIT];
            sdo_oe_q  <= 1'b1;
          end
        end
        HBFM_SHIFT: begin
          if (cs_n_s) begin
            state_q  <= HBFM_IDLE;
            sdo_oe_q <= 1'b0;
          end else begin
            if (sclk_rise) begin
              rx_q <= {sdi_s, rx_q[WORD_W-1:1]};
              // saturate above sixteen so an over-long frame is rejected
              if (bit_cnt_q <= WORD_BITS) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
              end
            end
            if (sclk_fall) begin
              tx_q  <= {1'b0, tx_q[WORD_W-1:1]};
              sdo_q <= tx_q[1];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q        <= CTRL_RESET;
      clear_pulse_q <= 1'b0;
    end else if (asleep) begin
      ctrl_q        <= CTRL_RESET;
      clear_pulse_q <= 1'b0;
    end else begin
      clear_pulse_q <= accept & rx_q[CLEAR_BIT];
      if (accept) begin
        ctrl_q <= rx_q;
      end
    end
  end

  // ****************************************************************
  // fault filters
  // ****************************************************************
  logic [CNT_W-1:0]  uv_cnt_q;
  logic [CNT_W-1:0]  ol_cnt_q [NUM_SW];
  logic [CNT_W-1:0]  oc_cnt_q [NUM_SW];
  logic [NUM_SW-1:0] ol_hit;
  logic [NUM_SW-1:0] oc_hit;
  logic              uv_hit;

  assign uv_hit = uv_s && (uv_cnt_q == UV_TERM);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      uv_cnt_q <= '0;
    end else if (asleep) begin
      uv_cnt_q <= '0;
    end else begin
      uv_cnt_q <= filt_step(uv_s, uv_cnt_q, UV_TERM);
    end
  end

  for (genvar i = 0; i < NUM_SW; i++) begin : g_sw
    // open load only makes sense while the switch is meant to conduct
    assign ol_hit[i] = switch_en_q[i] && ol_s[i] && (ol_cnt_q[i] == SD_TERM);
    assign oc_hit[i] = switch_en_q[i] && oc_s[i] && (oc_cnt_q[i] == SD_TERM);

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        ol_cnt_q[i] <= '0;
        oc_cnt_q[i] <= '0;
      end else if (asleep) begin
        ol_cnt_q[i] <= '0;
        oc_cnt_q[i] <= '0;
      end else begin
        ol_cnt_q[i] <= filt_step(switch_en_q[i] & ol_s[i], ol_cnt_q[i], SD_TERM);
        oc_cnt_q[i] <= filt_step(switch_en_q[i] & oc_s[i], oc_cnt_q[i], SD_TERM);
      end
    end
  end

  // ****************************************************************
  // latched flags, set wins over clear
  // ****************************************************************
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      uv_det_q      <= 1'b0;
      supply_fail_q <= 1'b0;
      open_load_q   <= 1'b0;
      short_q       <= 1'b0;
      prewarn_q     <= 1'b0;
    end else if (asleep) begin
      uv_det_q      <= 1'b0;
      supply_fail_q <= 1'b0;
      open_load_q   <= 1'b0;
      short_q       <= 1'b0;
      prewarn_q     <= 1'b0;
    end else begin
      uv_det_q      <= uv_hit || (uv_det_q && uv_s);
      supply_fail_q <= uv_hit || (supply_fail_q && !clear_pulse_q);
      open_load_q   <= (|ol_hit) || (open_load_q && !clear_pulse_q);
      short_q       <= (|oc_hit) || (short_q && !clear_pulse_q);
      prewarn_q     <= pw_s;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      therm_off_q <= 1'b0;
    end else if (asleep) begin
      therm_off_q <= 1'b0;
    end else if (shut_s) begin
      therm_off_q <= 1'b1;
    end else if (clear_pulse_q && cool_s) begin
      therm_off_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      trip_q <= '0;
    end else if (asleep) begin
      trip_q <= '0;
    end else begin
      // trip enable gates only the shutdown, the flag is set regardless
      trip_q <= (oc_hit & {NUM_SW{ctrl_q[TRIP_EN_BIT]}}) | (trip_q & ~{NUM_SW{clear_pulse_q}});
    end
  end

  // ****************************************************************
  // switch drive
  // ****************************************************************
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      switch_en_q <= '0;
      hiz_q       <= 1'b1;
    end else if (asleep) begin
      switch_en_q <= '0;
      hiz_q       <= 1'b1;
    end else begin
      switch_en_q <= ctrl_q[SW_LSB +: NUM_SW] & ~trip_q
                     & {NUM_SW{~uv_det_q & ~therm_off_q}};
      hiz_q       <= 1'b0;
    end
  end

  assign sdo_o              = sdo_q;
  assign sdo_oe_o           = sdo_oe_q;
  assign switch_en_o        = switch_en_q;
  assign outputs_hiz_o      = hiz_q;
  assign supply_fail_flag_o = supply_fail_q;
  assign open_load_flag_o   = open_load_q;
  assign short_trip_flag_o  = short_q;
  assign prewarn_flag_o     = prewarn_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  logic [CNT_W:0] uv_run_q;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      uv_run_q <= '0;
    end else if (!uv_s || asleep) begin
      uv_run_q <= '0;
    end else if (uv_run_q[CNT_W] == 1'b0) begin
      uv_run_q <= uv_run_q + 1'b1;
    end
  end

  a_uv_filter_time: assert property ($rose(uv_det_q) |-> $past(uv_run_q) >= (CNT_W+1)'(UV_CYC))
    else $error("undervoltage detected before filter time");
  a_uv_outputs_off: assert property (uv_det_q && !asleep |=> switch_en_q == '0)
    else $error("switch on during undervoltage");
  a_supply_flag_hold: assert property (supply_fail_q && !clear_pulse_q && !asleep |=> supply_fail_q)
    else $error("supply fail flag dropped without clear");
  a_prewarn_at_cs: assert property (state_q == HBFM_IDLE && !cs_n_s && !asleep
                                    |=> sdo_q == $past(prewarn_q) && sdo_oe_q)
    else $error("prewarn not shown at chip select fall");
  a_abort_keeps_ctrl: assert property (state_q == HBFM_SHIFT && cs_n_s && bit_cnt_q != WORD_BITS
                                       && !asleep |=> ctrl_q == $past(ctrl_q) && !clear_pulse_q)
    else $error("aborted transfer changed input word");
  a_therm_outputs_off: assert property (therm_off_q && !asleep |=> switch_en_q == '0)
    else $error("switch on during thermal shutdown");
  a_therm_hold: assert property (therm_off_q && !(clear_pulse_q && cool_s) && !asleep |=> therm_off_q)
    else $error("thermal shutdown released without clear");
  a_no_trip_disabled: assert property (!ctrl_q[TRIP_EN_BIT] && trip_q == '0 && !asleep |=> trip_q == '0)
    else $error("trip while overcurrent shutdown disabled");
  a_trip_switch_off: assert property (trip_q != '0 && !asleep |=> (switch_en_q & $past(trip_q)) == '0)
    else $error("tripped switch still on");
  a_clear_short: assert property (clear_pulse_q && oc_hit == '0 && !asleep |=> !short_q && trip_q == '0)
    else $error("status clear left short flag");
  a_sleep_erase: assert property (asleep |=> ctrl_q == CTRL_RESET && switch_en_q == '0 && hiz_q)
    else $error("sleep did not erase state");

endmodule

// *** include/hbfm_pkg.sv ***
package hbfm_pkg;

  // ****************************************************************
  // word layout
  // ****************************************************************
  localparam int          WORD_W       = 16;
  localparam int          NUM_SW       = 6;
  localparam int          PREWARN_BIT  = 0;
  localparam int          SW_LSB       = 1;
  localparam int          SHORT_BIT    = 13;
  localparam int          OPEN_BIT     = 14;
  localparam int          SUPPLY_BIT   = 15;
  localparam int          CLEAR_BIT    = 0;
  localparam int          TRIP_EN_BIT  = 13;
  localparam logic [15:0] CTRL_RESET   = 16'h2000;
  localparam logic [4:0]  WORD_BITS    = 5'h10;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS        = 4;
  localparam int UNDERVOLT_FILTER_NS  = 10000;
  localparam int SHUTDOWN_FILTER_NS   = 10000;
  localparam int SCLK_MAX_KHZ         = 2000;
  localparam int UV_FILTER_CYC =
    (UNDERVOLT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SD_FILTER_CYC =
    (SHUTDOWN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // serial link states
  // ****************************************************************
  typedef enum logic [1:0] {
    HBFM_IDLE  = 2'b01,
    HBFM_SHIFT = 2'b10
  } hbfm_link_t;

endpackage

// *** dv/hbfm_ctrl_model.sv ***
`timescale 1ns/1ps
module hbfm_ctrl_model
  import hbfm_pkg::*;
#(
  parameter int HALF_CYC = 8
) (
  input  wire logic sys_clk_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      sdi_o
);

  // ****************************************************************
  // serial controller, lsb first, sclk idle low
  // ****************************************************************
  // the bench runs the link far above the device limit to keep runs short
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // nbits other than WORD_W ends the frame short or over-long, as an abort
  task automatic xfer(input logic [WORD_W-1:0] wr, input int nbits,
                      output logic [WORD_W-1:0] rd);
    rd     = 'x;
    cs_n_o = 1'b0;
    sdi_o  = wr[0];
    tick(HALF_CYC);
    rd[0] = sdo_oe_i ? sdo_i : 1'bx;
    for (int i = 0; i < nbits; i++) begin
      sclk_o = 1'b1;
      tick(HALF_CYC);
      rd[i] = sdo_oe_i ? sdo_i : 1'bx;
      sclk_o = 1'b0;
      sdi_o  = (i + 1 < nbits) ? wr[i+1] : ~sdi_o;
      tick(HALF_CYC);
    end
    cs_n_o = 1'b1;
    sdi_o  = ~sdi_o;
    tick(HALF_CYC);
  endtask

endmodule

// *** dv/hbfm_monitor_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(name, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("wrong value %s expected %h seen %h", name, exp, got); \
    end \
  end

module hbfm_monitor_tb_top;
  import hbfm_pkg::*;

  logic              sys_clk_i = 1'b0;
  logic              reset_i   = 1'b1;
  logic              sleep_input_n_i   = 1'b1;
  logic              load_supply_low_i = 1'b0;
  logic [NUM_SW-1:0] open_load_raw_i   = '0;
  logic [NUM_SW-1:0] overcurrent_raw_i = '0;
  logic              prewarn_on_temp_i = 1'b0;
  logic              shutdown_temp_i   = 1'b0;
  logic              below_on_temp_i   = 1'b1;
  logic              cs_n, sclk, sdi, sdo_o, sdo_oe_o, outputs_hiz_o;
  logic [NUM_SW-1:0] switch_en_o;
  logic              supply_fail_flag_o, open_load_flag_o, short_trip_flag_o, prewarn_flag_o;
  logic [WORD_W-1:0] rd;
  int                errors   = 0;
  int                n_checks = 0;

  always #2 sys_clk_i = ~sys_clk_i;

  hbfm_monitor #(.UV_CYC(8), .SD_CYC(8)) i_hbfm_monitor (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .sleep_input_n_i(sleep_input_n_i),
    .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .load_supply_low_i(load_supply_low_i),
    .open_load_raw_i(open_load_raw_i), .overcurrent_raw_i(overcurrent_raw_i),
    .prewarn_on_temp_i(prewarn_on_temp_i), .shutdown_temp_i(shutdown_temp_i),
    .below_on_temp_i(below_on_temp_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .switch_en_o(switch_en_o), .outputs_hiz_o(outputs_hiz_o),
    .supply_fail_flag_o(supply_fail_flag_o), .open_load_flag_o(open_load_flag_o),
    .short_trip_flag_o(short_trip_flag_o), .prewarn_flag_o(prewarn_flag_o));

  hbfm_ctrl_model i_hbfm_ctrl_model (
    .sys_clk_i(sys_clk_i), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o),
    .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wr(input logic [WORD_W-1:0] w);
    i_hbfm_ctrl_model.xfer(w, WORD_W, rd);
    cyc(6);
  endtask

  function automatic logic [WORD_W-1:0] stat(logic sf, logic ol, logic sc,
                                              logic [5:0] sw, logic pw);
    return {sf, ol, sc, 6'h00, sw, pw};
  endfunction

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    results();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    cyc(8);
    reset_i = 1'b0;
    cyc(6);
    `CHK("switch_en", 6'h00, switch_en_o)
    `CHK("hiz", 1'b0, outputs_hiz_o)
    wr(16'h207e);
    `CHK("switch_en", 6'h3f, switch_en_o)
    i_hbfm_ctrl_model.xfer(16'h207e, WORD_W, rd);
    `CHK("status", stat(0, 0, 0, 6'h3f, 0), rd)
    done("enable");

    prewarn_on_temp_i = 1'b1;
    cyc(6);
    `CHK("prewarn", 1'b1, prewarn_flag_o)
    i_hbfm_ctrl_model.xfer(16'h0000, 0, rd);
    `CHK("sdo bit0", 1'b1, rd[0])
    i_hbfm_ctrl_model.xfer(16'h0000, 8, rd);
    cyc(6);
    `CHK("switch_en", 6'h3f, switch_en_o)
    prewarn_on_temp_i = 1'b0;
    cyc(6);
    `CHK("prewarn", 1'b0, prewarn_flag_o)
    done("prewarn");

    load_supply_low_i = 1'b1;
    cyc(5);
    load_supply_low_i = 1'b0;
    cyc(2);
    load_supply_low_i = 1'b1;
    cyc(5);
    load_supply_low_i = 1'b0;
    cyc(6);
    `CHK("supply_fail", 1'b0, supply_fail_flag_o)
    load_supply_low_i = 1'b1;
    cyc(20);
    `CHK("supply_fail", 1'b1, supply_fail_flag_o)
    `CHK("switch_en", 6'h00, switch_en_o)
    load_supply_low_i = 1'b0;
    cyc(8);
    `CHK("switch_en", 6'h3f, switch_en_o)
    `CHK("supply_fail", 1'b1, supply_fail_flag_o)
    i_hbfm_ctrl_model.xfer(16'h0000, 5, rd);
    cyc(6);
    `CHK("supply_fail", 1'b1, supply_fail_flag_o)
    wr(16'h207f);
    `CHK("supply_fail", 1'b0, supply_fail_flag_o)
    done("supply");

    open_load_raw_i = 6'h01;
    cyc(20);
    open_load_raw_i = 6'h00;
    cyc(6);
    `CHK("open_load", 1'b1, open_load_flag_o)
    `CHK("open_load", 1'b1, open_load_flag_o)
    wr(16'h207f);
    `CHK("open_load", 1'b0, open_load_flag_o)
    done("open_load");

    overcurrent_raw_i = 6'h04;
    cyc(20);
    `CHK("short", 1'b1, short_trip_flag_o)
    `CHK("switch_en", 6'h3b, switch_en_o)
    i_hbfm_ctrl_model.xfer(16'h0000, WORD_W, rd);
    `CHK("status", stat(0, 0, 1, 6'h3b, 0), rd)
    overcurrent_raw_i = 6'h00;
    wr(16'h207f);
    `CHK("short", 1'b0, short_trip_flag_o)
    `CHK("switch_en", 6'h3f, switch_en_o)
    wr(16'h007e);
    overcurrent_raw_i = 6'h02;
    cyc(20);
    `CHK("short", 1'b1, short_trip_flag_o)
    `CHK("switch_en", 6'h3f, switch_en_o)
    overcurrent_raw_i = 6'h00;
    wr(16'h207f);
    `CHK("short", 1'b0, short_trip_flag_o)
    done("overcurrent");

    shutdown_temp_i = 1'b1;
    below_on_temp_i = 1'b0;
    cyc(8);
    `CHK("switch_en", 6'h00, switch_en_o)
    shutdown_temp_i = 1'b0;
    wr(16'h207f);
    `CHK("switch_en", 6'h00, switch_en_o)
    below_on_temp_i = 1'b1;
    cyc(4);
    `CHK("switch_en", 6'h00, switch_en_o)
    wr(16'h207f);
    `CHK("switch_en", 6'h3f, switch_en_o)
    done("thermal");

    load_supply_low_i = 1'b1;
    cyc(20);
    load_supply_low_i = 1'b0;
    sleep_input_n_i = 1'b0;
    cyc(6);
    `CHK("hiz", 1'b1, outputs_hiz_o)
    `CHK("switch_en", 6'h00, switch_en_o)
    `CHK("supply_fail", 1'b0, supply_fail_flag_o)
    sleep_input_n_i = 1'b1;
    cyc(8);
    `CHK("hiz", 1'b0, outputs_hiz_o)
    i_hbfm_ctrl_model.xfer(16'h0000, WORD_W, rd);
    `CHK("status", stat(0, 0, 0, 6'h00, 0), rd)
    done("sleep");
    results();
  end

endmodule
